// File: src/bpps_pkg.sv
// Package for the bus and peripheral pin sharing block: pin indices, reset values, carriers.
// Assumes a single 100 MHz system clock and synchronous active-high reset.
package bpps_pkg;
	// Port A bits: area selects 1..5 on bits 1..5, bus clock on bit 6
	localparam int PA_CS_LO      = 1;
	localparam int PA_CS_HI      = 5;
	localparam int PA_CLK_BIT    = 6;
	localparam int PA_DMA_END_PROCESS_CH1_BIT   = 3;
	// Port B bits: DRAM bank 0 on 0..3, bank 1 on 4..7
	localparam int PB_BANK1_BASE = 4;
	localparam int PB_DMA_END_PROCESS_CH2_BIT   = 4;
	localparam int PB_DMA_REQUEST_CH2_BIT  = 5;
	localparam int PB_DMA_ACKNOWLEDGE_CH2_BIT  = 6;
	// Port E bits
	localparam int PE_SC1_BIT    = 2;
	localparam int PE_SC2_BIT    = 3;
	localparam int PE_DMA_REQUEST_CH0_BIT  = 4;
	localparam int PE_DREQ1_BIT  = 5;
	localparam int PE_DMA_ACKNOWLEDGE_CH0_BIT  = 6;
	localparam int PE_DACK1_BIT  = 7;
	// Port F bits
	localparam int PF_SI0_BIT    = 0;
	// Reset values
	localparam logic [7:0] PORT_RST   = 8'h00;
	localparam logic [1:0] CLKDIV_RST = 2'h0;
	localparam logic       SYNC_RST   = 1'b0;
	// Bus clock: half of system rate, toggles each system cycle
	localparam int SYS_CLK_MHZ   = 100;
	localparam int BUS_CLK_MHZ   = 50;
	localparam int BUS_HALF_CYC  = SYS_CLK_MHZ / (2 * BUS_CLK_MHZ);

	// One DRAM bank's strobes, all active low
	typedef struct packed {
		logic write_n;
		logic col_high_n;
		logic col_low_n;
		logic row_n;
	} bpps_dram_type;

	// One 8-bit port: output data and direction
	typedef struct packed {
		logic [7:0] dout;
		logic [7:0] dir;
	} bpps_port_type;
endpackage

// File: src/bpps_pin_cell.sv
// One pin slot per bit: peripheral output wins over port output.
// Assumes all controls are synchronous to sys_clk.
`timescale 1ns/1ps
module bpps_pin_cell import bpps_pkg::*; (
	input  wire logic [7:0] periph_en,
	input  wire logic [7:0] periph_out,
	input  wire logic [7:0] input_only,
	input  wire bpps_port_type port_cfg,
	output logic      [7:0] pin_out,
	output logic      [7:0] pin_oe
);
	genvar i;
	// Peripheral first, then forced input, then port
	generate
		for (i = 0; i < 8; i++) begin : g_bit
			assign pin_out[i] = periph_en[i] ? periph_out[i] : port_cfg.dout[i];
			assign pin_oe[i]  = periph_en[i] | (~input_only[i] & port_cfg.dir[i]);
		end
	endgenerate
endmodule // bpps_pin_cell

// File: src/bpps_clk_div.sv
// Bus clock generator: divides sys_clk, gives a level clock and an enable pulse.
// Assumes synchronous active-high reset.
`timescale 1ns/1ps
module bpps_clk_div import bpps_pkg::*; (
	input  wire logic sys_clk,
	input  wire logic reset,
	output logic      bus_clk_level,
	output logic      bus_clk_en
);
	logic [1:0] cnt_reg;
	logic       lvl_reg;
	// Toggle the bus clock level every BUS_HALF_CYC cycles
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			cnt_reg <= CLKDIV_RST;
			lvl_reg <= 1'b0;
		end else if (cnt_reg == 2'(BUS_HALF_CYC - 1)) begin
			cnt_reg <= CLKDIV_RST;
			lvl_reg <= ~lvl_reg;
		end else begin
			cnt_reg <= cnt_reg + 2'h1;
		end
	end
	assign bus_clk_level = lvl_reg;
	assign bus_clk_en    = (cnt_reg == 2'(BUS_HALF_CYC - 1)) & ~lvl_reg;
endmodule // bpps_clk_div

// File: src/bpps_top.sv
// Top of the bus and peripheral pin sharing block: ports A, B, E, F.
// Assumes peripherals and the port registers live outside and hand in levels.
//
// Functional notes
// - Six area selects 0..5 drive low to select, high otherwise.
// - Bus clock pin outputs bus clock when enabled, else port bit.
// - Every shared pin is a port bit when no peripheral uses it.
// - End-of-process ch1/ch2 appear only while their output is enabled.
// - Acknowledge ch0..2 drive only while enabled (ch2 also only while DRAM bank 1 bit 2 is off); else port function or that DRAM strobe.
// - Request pins sampled when external trigger chosen; outputs disabled then.
// - Four interrupt pins are inputs while enabled, but an enabled serial clock 1/2 still drives bit 2/3; other outputs disabled.
// - Serial clocks 1,2 drive only while clock output enabled.
// - Serial 0 receive pin doubles as timer trigger; outputs off when used.
// - Non-maskable interrupt is asserted when its pin is low.
// - Standby input asserted when low puts device in standby.
// - Each DRAM bank drives row, column low, column high, write strobes, but choosing the request ch2 external trigger disables bank 1 column low.
// - Peripheral output always wins over port output on a pin.
`timescale 1ns/1ps
module bpps_top import bpps_pkg::*; (
	input  wire logic          sys_clk,
	input  wire logic          reset,
	// Bus controller side
	input  wire logic [5:0]    area_select_n,
	input  wire logic [5:1]    area_select_en,
	input  wire logic          bus_clk_out_en,
	input  wire bpps_dram_type dram_bank0,
	input  wire bpps_dram_type dram_bank1,
	input  wire logic [3:0]    dram_bank0_en,
	input  wire logic [3:0]    dram_bank1_en,
	// DMA side
	input  wire logic [2:1]    dma_end_process,
	input  wire logic [2:1]    dma_end_process_en,
	input  wire logic [2:0]    dma_acknowledge,
	input  wire logic [2:0]    dma_acknowledge_en,
	input  wire logic [2:0]    dma_ext_trigger_sel,
	output logic      [2:0]    dma_request,
	// Interrupt, standby, serial and timer side
	input  wire logic [3:0]    ext_irq_en,
	output logic      [3:0]    ext_irq,
	output logic               nmi_asserted,
	output logic               standby_req,
	input  wire logic [2:1]    serial_clock_out,
	input  wire logic [2:1]    serial_clock_out_en,
	input  wire logic          serial0_rx_en,
	input  wire logic          pwm_trigger_en_0,
	output logic               serial0_rx,
	output logic               pwm_trigger_in_0,
	// Port registers
	input  wire bpps_port_type port_a_cfg,
	input  wire bpps_port_type port_b_cfg,
	input  wire bpps_port_type port_e_cfg,
	input  wire bpps_port_type port_f_cfg,
	output logic      [7:0]    port_a_in,
	output logic      [7:0]    port_b_in,
	output logic      [7:0]    port_e_in,
	output logic      [7:0]    port_f_in,
	// Pins
	output logic               area_select_0_n,
	input  wire logic [7:0]    pa_i,
	output logic      [7:0]    pa_o,
	output logic      [7:0]    pa_oe,
	input  wire logic [7:0]    pb_i,
	output logic      [7:0]    pb_o,
	output logic      [7:0]    pb_oe,
	input  wire logic [7:0]    pe_i,
	output logic      [7:0]    pe_o,
	output logic      [7:0]    pe_oe,
	input  wire logic          nmi_n,
	input  wire logic          hw_standby_n,
	input  wire logic [7:0]    pf_i,
	output logic      [7:0]    pf_o,
	output logic      [7:0]    pf_oe
);
	logic       bus_clk_level;
	logic [7:0] pa_en, pa_val, pb_en, pb_val, pe_en, pe_val, pf_en, pf_val;
	logic [7:0] pa_in_only, pb_in_only, pe_in_only, pf_in_only;
	logic [7:0] pa_o_next, pb_o_next, pe_o_next, pf_o_next;
	logic [7:0] pa_oe_next, pb_oe_next, pe_oe_next, pf_oe_next;
	logic [7:0] pa_o_reg, pb_o_reg, pe_o_reg, pf_o_reg;
	logic [7:0] pa_oe_reg, pb_oe_reg, pe_oe_reg, pf_oe_reg;
	logic       cs0_reg;
	logic [7:0] pa_in_reg, pb_in_reg, pe_in_reg, pf_in_reg;
	logic       nmi_reg, stby_reg;

	bpps_clk_div u_div (
		.sys_clk      (sys_clk),
		.reset        (reset),
		.bus_clk_level(bus_clk_level),
		.bus_clk_en   ()
	);

	// Port A: area selects 1..5, end-of-process ch1, bus clock
	always_comb begin
		pa_en      = 8'h00;
		pa_val     = 8'hFF;
		pa_in_only = 8'h00;
		pa_en[PA_CS_HI:PA_CS_LO]  = area_select_en;
		pa_val[PA_CS_HI:PA_CS_LO] = area_select_n[PA_CS_HI:PA_CS_LO];
		if (!area_select_en[PA_DMA_END_PROCESS_CH1_BIT] && dma_end_process_en[1]) begin
			pa_en[PA_DMA_END_PROCESS_CH1_BIT]  = 1'b1;
			pa_val[PA_DMA_END_PROCESS_CH1_BIT] = dma_end_process[1];
		end
		pa_en[PA_CLK_BIT]  = bus_clk_out_en;
		pa_val[PA_CLK_BIT] = bus_clk_level;
	end

	// Port B: DRAM banks, end-of-process ch2, request ch2, acknowledge ch2
	always_comb begin
		pb_en      = {dram_bank1_en, dram_bank0_en};
		pb_val     = {dram_bank1, dram_bank0};
		pb_in_only = 8'h00;
		if (!dram_bank1_en[0] && dma_end_process_en[2]) begin
			pb_en[PB_DMA_END_PROCESS_CH2_BIT]  = 1'b1;
			pb_val[PB_DMA_END_PROCESS_CH2_BIT] = dma_end_process[2];
		end
		if (dma_ext_trigger_sel[2]) begin
			pb_en[PB_DMA_REQUEST_CH2_BIT]      = 1'b0;
			pb_in_only[PB_DMA_REQUEST_CH2_BIT] = 1'b1;
		end
		if (!dram_bank1_en[2] && dma_acknowledge_en[2]) begin
			pb_en[PB_DMA_ACKNOWLEDGE_CH2_BIT]  = 1'b1;
			pb_val[PB_DMA_ACKNOWLEDGE_CH2_BIT] = dma_acknowledge[2];
		end
	end

	// Port E: interrupts 0..3, serial clocks, requests ch0/1, acknowledges ch0/1
	always_comb begin
		pe_en      = 8'h00;
		pe_val     = 8'h00;
		pe_in_only = 8'h00;
		pe_en[PE_SC1_BIT]   = serial_clock_out_en[1];
		pe_val[PE_SC1_BIT]  = serial_clock_out[1];
		pe_en[PE_SC2_BIT]   = serial_clock_out_en[2];
		pe_val[PE_SC2_BIT]  = serial_clock_out[2];
		pe_en[PE_DMA_ACKNOWLEDGE_CH0_BIT]  = dma_acknowledge_en[0];
		pe_val[PE_DMA_ACKNOWLEDGE_CH0_BIT] = dma_acknowledge[0];
		pe_en[PE_DACK1_BIT]  = dma_acknowledge_en[1];
		pe_val[PE_DACK1_BIT] = dma_acknowledge[1];
		pe_in_only[3:0] = ext_irq_en;
		pe_in_only[PE_DMA_REQUEST_CH0_BIT] = dma_ext_trigger_sel[0];
		pe_in_only[PE_DREQ1_BIT] = dma_ext_trigger_sel[1];
	end

	// Port F: serial 0 receive and timer trigger force input
	always_comb begin
		pf_en      = 8'h00;
		pf_val     = 8'h00;
		pf_in_only = 8'h00;
		pf_in_only[PF_SI0_BIT] = serial0_rx_en | pwm_trigger_en_0;
	end

	bpps_pin_cell u_pa (
		.periph_en (pa_en),
		.periph_out(pa_val),
		.input_only(pa_in_only),
		.port_cfg  (port_a_cfg),
		.pin_out   (pa_o_next),
		.pin_oe    (pa_oe_next)
	);
	bpps_pin_cell u_pb (
		.periph_en (pb_en),
		.periph_out(pb_val),
		.input_only(pb_in_only),
		.port_cfg  (port_b_cfg),
		.pin_out   (pb_o_next),
		.pin_oe    (pb_oe_next)
	);
	bpps_pin_cell u_pe (
		.periph_en (pe_en),
		.periph_out(pe_val),
		.input_only(pe_in_only),
		.port_cfg  (port_e_cfg),
		.pin_out   (pe_o_next),
		.pin_oe    (pe_oe_next)
	);
	bpps_pin_cell u_pf (
		.periph_en (pf_en),
		.periph_out(pf_val),
		.input_only(pf_in_only),
		.port_cfg  (port_f_cfg),
		.pin_out   (pf_o_next),
		.pin_oe    (pf_oe_next)
	);

	// Register pin drives; reset leaves all shared pins as undriven inputs
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			pa_o_reg  <= PORT_RST;
			pb_o_reg  <= PORT_RST;
			pe_o_reg  <= PORT_RST;
			pf_o_reg  <= PORT_RST;
			pa_oe_reg <= PORT_RST;
			pb_oe_reg <= PORT_RST;
			pe_oe_reg <= PORT_RST;
			pf_oe_reg <= PORT_RST;
			cs0_reg   <= 1'b1;
		end else begin
			pa_o_reg  <= pa_o_next;
			pb_o_reg  <= pb_o_next;
			pe_o_reg  <= pe_o_next;
			pf_o_reg  <= pf_o_next;
			pa_oe_reg <= pa_oe_next;
			pb_oe_reg <= pb_oe_next;
			pe_oe_reg <= pe_oe_next;
			pf_oe_reg <= pf_oe_next;
			cs0_reg   <= area_select_n[0];
		end
	end

	// Sample pin levels for ports and input functions
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			pa_in_reg <= PORT_RST;
			pb_in_reg <= PORT_RST;
			pe_in_reg <= PORT_RST;
			pf_in_reg <= PORT_RST;
			nmi_reg   <= SYNC_RST;
			stby_reg  <= SYNC_RST;
		end else begin
			pa_in_reg <= pa_i;
			pb_in_reg <= pb_i;
			pe_in_reg <= pe_i;
			pf_in_reg <= pf_i;
			nmi_reg   <= ~nmi_n;
			stby_reg  <= ~hw_standby_n;
		end
	end

	assign pa_o            = pa_o_reg;
	assign pb_o            = pb_o_reg;
	assign pe_o            = pe_o_reg;
	assign pf_o            = pf_o_reg;
	assign pa_oe           = pa_oe_reg;
	assign pb_oe           = pb_oe_reg;
	assign pe_oe           = pe_oe_reg;
	assign pf_oe           = pf_oe_reg;
	assign area_select_0_n = cs0_reg;
	assign port_a_in       = pa_in_reg;
	assign port_b_in       = pb_in_reg;
	assign port_e_in       = pe_in_reg;
	assign port_f_in       = pf_in_reg;
	assign nmi_asserted    = nmi_reg;
	assign standby_req     = stby_reg;

	// Input functions gated by their selects
	assign dma_request[0] = dma_ext_trigger_sel[0] & pe_in_reg[PE_DMA_REQUEST_CH0_BIT];
	assign dma_request[1] = dma_ext_trigger_sel[1] & pe_in_reg[PE_DREQ1_BIT];
	assign dma_request[2] = dma_ext_trigger_sel[2] & pb_in_reg[PB_DMA_REQUEST_CH2_BIT];
	assign ext_irq        = ext_irq_en & pe_in_reg[3:0];
	assign serial0_rx       = serial0_rx_en ? pf_in_reg[PF_SI0_BIT] : 1'b1;
	assign pwm_trigger_in_0 = pwm_trigger_en_0 & pf_in_reg[PF_SI0_BIT];

	// Peripheral drive wins and reaches the pin one cycle later
	AST_PERIPH_WINS: assert property (@(posedge sys_clk) disable iff (reset)
		pe_en[PE_DMA_ACKNOWLEDGE_CH0_BIT] |=> pe_oe[PE_DMA_ACKNOWLEDGE_CH0_BIT] && pe_o[PE_DMA_ACKNOWLEDGE_CH0_BIT] == $past(dma_acknowledge[0]))
		else $error("Acknowledge ch0 not on its pin");
	AST_CS_LOW: assert property (@(posedge sys_clk) disable iff (reset)
		area_select_en[2] && !area_select_n[2] |=> pa_oe[2] && !pa_o[2])
		else $error("Area select 2 not low");
	AST_CLK_OUT: assert property (@(posedge sys_clk) disable iff (reset)
		bus_clk_out_en |=> pa_oe[PA_CLK_BIT] && pa_o[PA_CLK_BIT] == $past(bus_clk_level))
		else $error("Bus clock not on pin");
	AST_PORT_FALLBACK: assert property (@(posedge sys_clk) disable iff (reset)
		!pa_en[5] |=> pa_oe[5] == $past(port_a_cfg.dir[5]) && pa_o[5] == $past(port_a_cfg.dout[5]))
		else $error("Idle pin not following port");
	AST_DMA_END_PROCESS_CH1_GATE: assert property (@(posedge sys_clk) disable iff (reset)
		!area_select_en[PA_DMA_END_PROCESS_CH1_BIT] && !dma_end_process_en[1] |=>
		pa_oe[PA_DMA_END_PROCESS_CH1_BIT] == $past(port_a_cfg.dir[PA_DMA_END_PROCESS_CH1_BIT]))
		else $error("End of process ch1 drives while disabled");
	AST_DMA_ACKNOWLEDGE_CH2: assert property (@(posedge sys_clk) disable iff (reset)
		!dram_bank1_en[2] && dma_acknowledge_en[2] |=> pb_o[PB_DMA_ACKNOWLEDGE_CH2_BIT] == $past(dma_acknowledge[2]))
		else $error("Acknowledge ch2 missing");
	AST_DREQ_INPUT: assert property (@(posedge sys_clk) disable iff (reset)
		dma_ext_trigger_sel[0] |=> !pe_oe[PE_DMA_REQUEST_CH0_BIT])
		else $error("Request pin driven while sampled");
	AST_IRQ_INPUT: assert property (@(posedge sys_clk) disable iff (reset)
		ext_irq_en[0] && !serial_clock_out_en[1] |=> !pe_oe[0])
		else $error("Interrupt pin driven");
	AST_SC_GATE: assert property (@(posedge sys_clk) disable iff (reset)
		!serial_clock_out_en[2] && !ext_irq_en[PE_SC2_BIT] |=>
		pe_oe[PE_SC2_BIT] == $past(port_e_cfg.dir[PE_SC2_BIT]))
		else $error("Serial clock 2 drives while off");
	AST_SI0_INPUT: assert property (@(posedge sys_clk) disable iff (reset)
		pwm_trigger_en_0 |=> !pf_oe[PF_SI0_BIT])
		else $error("Receive pin driven");
	AST_NMI_LOW: assert property (@(posedge sys_clk) disable iff (reset)
		!nmi_n |=> nmi_asserted)
		else $error("NMI not seen");
	// Standby pin released after a low phase; request must drop one cycle later
	sequence standby_release_seq;
		!hw_standby_n ##1 hw_standby_n;
	endsequence
	AST_STBY_LOW: assert property (@(posedge sys_clk) disable iff (reset)
		standby_release_seq |=> !standby_req)
		else $error("Standby wrong");
	AST_STBY_ENTER: assert property (@(posedge sys_clk) disable iff (reset)
		!hw_standby_n |=> standby_req)
		else $error("Standby not requested");
	AST_DMA_REQUEST_CH2_INPUT: assert property (@(posedge sys_clk) disable iff (reset)
		dma_ext_trigger_sel[2] |=> !pb_oe[PB_DMA_REQUEST_CH2_BIT])
		else $error("Request ch2 pin driven while sampled");
	AST_DACK1_OFF: assert property (@(posedge sys_clk) disable iff (reset)
		!dma_acknowledge_en[1] |=> pe_oe[PE_DACK1_BIT] == $past(port_e_cfg.dir[PE_DACK1_BIT]))
		else $error("Acknowledge ch1 drives while disabled");
	AST_DRAM_ROW: assert property (@(posedge sys_clk) disable iff (reset)
		dram_bank1_en[0] && !dram_bank1.row_n |=> pb_oe[PB_BANK1_BASE] && !pb_o[PB_BANK1_BASE])
		else $error("Row strobe bank1 missing");
endmodule // bpps_top

// File: dv/bpps_board_model.sv
// Board-side model of one 8-bit shared port: resolves each wire's level.
// Assumes the device output enable is high while the device drives the pin.
`timescale 1ns/1ps
module bpps_board_model (
	input  wire logic [7:0] dev_o,
	input  wire logic [7:0] dev_oe,
	input  wire logic [7:0] board_drv,
	output logic      [7:0] pin_level
);
	// Requesters and interrupt sources drive only bits the device released
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			pin_level[i] = dev_oe[i] ? dev_o[i] : board_drv[i];
		end
	end
endmodule // bpps_board_model

// File: dv/tb_top.sv
// Self-checking bench for the pin sharing top: notes queue plus output monitor.
// Assumes the board model resolves every port wire from the device enables.
`timescale 1ns/1ps
module tb_top;
	import bpps_pkg::*;
	typedef struct {int sel; logic [7:0] exp;} bpps_note_type;
	logic          sys_clk, reset, bus_clk_out_en, nmi_n, hw_standby_n, area_select_0_n;
	logic [5:0]    area_select_n;
	logic [5:1]    area_select_en;
	bpps_dram_type dram_bank0, dram_bank1;
	logic [3:0]    dram_bank0_en, dram_bank1_en, ext_irq_en, ext_irq;
	logic [2:1]    dma_end_process, dma_end_process_en, serial_clock_out, serial_clock_out_en;
	logic [2:0]    dma_acknowledge, dma_acknowledge_en, dma_ext_trigger_sel, dma_request;
	logic          nmi_asserted, standby_req, serial0_rx_en, pwm_trigger_en_0;
	logic          serial0_rx, pwm_trigger_in_0, chk_now, prev_pa6;
	bpps_port_type port_a_cfg, port_b_cfg, port_e_cfg, port_f_cfg;
	logic [7:0]    port_a_in, port_b_in, port_e_in, port_f_in, board_a, board_b, board_e, board_f;
	logic [7:0]    pa_i, pa_o, pa_oe, pb_i, pb_o, pb_oe, pe_i, pe_o, pe_oe, pf_i, pf_o, pf_oe;
	int            error_cnt = 0;
	int            n_compared = 0;
	int            seed = 98360;
	bpps_note_type notes[$];

	bpps_top bpps_top_inst (
		.sys_clk, .reset, .area_select_n, .area_select_en, .bus_clk_out_en, .dram_bank0,
		.dram_bank1, .dram_bank0_en, .dram_bank1_en, .dma_end_process, .dma_end_process_en,
		.dma_acknowledge, .dma_acknowledge_en, .dma_ext_trigger_sel, .dma_request,
		.ext_irq_en, .ext_irq, .nmi_asserted, .standby_req, .serial_clock_out,
		.serial_clock_out_en, .serial0_rx_en, .pwm_trigger_en_0, .serial0_rx, .pwm_trigger_in_0,
		.port_a_cfg, .port_b_cfg, .port_e_cfg, .port_f_cfg, .port_a_in, .port_b_in, .port_e_in,
		.port_f_in, .area_select_0_n, .pa_i, .pa_o, .pa_oe, .pb_i, .pb_o, .pb_oe, .pe_i, .pe_o,
		.pe_oe, .nmi_n, .hw_standby_n, .pf_i, .pf_o, .pf_oe
	);
	// One board model per shared port
	bpps_board_model board_a_inst (
		.dev_o(pa_o), .dev_oe(pa_oe), .board_drv(board_a), .pin_level(pa_i)
	);
	bpps_board_model board_b_inst (
		.dev_o(pb_o), .dev_oe(pb_oe), .board_drv(board_b), .pin_level(pb_i)
	);
	bpps_board_model board_e_inst (
		.dev_o(pe_o), .dev_oe(pe_oe), .board_drv(board_e), .pin_level(pe_i)
	);
	bpps_board_model board_f_inst (
		.dev_o(pf_o), .dev_oe(pf_oe), .board_drv(board_f), .pin_level(pf_i)
	);

	// Free-running system clock
	always #5 sys_clk = ~sys_clk;

	// Monitor: takes the oldest notes when the driver flags settled outputs
	always @(posedge sys_clk) begin
		bpps_note_type n;
		#1;
		while (chk_now && notes.size() > 0) begin
			n = notes.pop_front();
			compare(seen_of(n.sel), n.exp);
		end
		prev_pa6 = pa_o[6];
	end

	// Watchdog against a hung run
	initial begin
		#100000;
		error_cnt++;
		finish_test();
	end

	function automatic logic [7:0] seen_of(input int sel);
		case (sel)
			0: return pa_o & pa_oe;
			1: return pa_oe;
			2: return pb_o & pb_oe;
			3: return pb_oe;
			4: return pe_o & pe_oe;
			5: return pe_oe;
			6: return pf_oe;
			7: return {1'b0, dma_request, ext_irq};
			8: return {3'h0, area_select_0_n, pwm_trigger_in_0, serial0_rx, standby_req, nmi_asserted};
			9: return {7'h00, pa_o[6] ^ prev_pa6};
			10: return port_e_in;
			11: return port_f_in;
			12: return port_a_in;
			default: return port_b_in;
		endcase
	endfunction
	// Expected enable and masked output: peripheral bits win, input-only bits stay off
	function automatic logic [7:0] exp_oe(input logic [7:0] m, dir, io);
		return m | (dir & ~io);
	endfunction
	function automatic logic [7:0] exp_o(input logic [7:0] per, m, dout, dir, io);
		return (per & m) | (dout & dir & ~m & ~io);
	endfunction
	task automatic compare(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic expect_val(input int sel, input logic [7:0] exp);
		notes.push_back('{sel, exp});
	endtask
	// Hold stimulus, then flag one monitor pass
	task automatic settle();
		repeat (3) @(negedge sys_clk);
		chk_now = 1'b1;
		@(negedge sys_clk);
		chk_now = 1'b0;
	endtask
	task automatic idle();
		{area_select_en, bus_clk_out_en, dram_bank0_en, dram_bank1_en, dma_end_process_en} = '0;
		{dma_acknowledge_en, dma_ext_trigger_sel, ext_irq_en, serial_clock_out_en} = '0;
		{serial0_rx_en, pwm_trigger_en_0, dma_end_process, dma_acknowledge, serial_clock_out} = '0;
		{area_select_n, dram_bank0, dram_bank1, nmi_n, hw_standby_n} = '1;
		{port_a_cfg, port_b_cfg, port_e_cfg, port_f_cfg, board_a, board_b, board_e, board_f} = '0;
	endtask
	task automatic finish_test();
		$display("compared=%0d errors=%0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Main sequence: reset, then each sharing case, all but the bus clock case with fresh random data
	initial begin
		logic [31:0] r, q;
		logic [7:0]  m, io, oe, lv;
		sys_clk = 1'b0;
		reset = 1'b1;
		chk_now = 1'b0;
		prev_pa6 = 1'b0;
		idle();
		port_a_cfg = '{dout: 8'hFF, dir: 8'hFF};
		area_select_n = 6'h00;
		expect_val(1, 8'h00);
		expect_val(3, 8'h00);
		settle();
		repeat (8) @(negedge sys_clk);
		reset = 1'b0;
		for (int it = 0; it < 6; it++) begin
			idle();
			r = $random(seed);
			area_select_en = 5'h1F;
			area_select_n = r[5:0];
			port_a_cfg = '{dout: r[15:8], dir: 8'hFF};
			expect_val(0, {r[15:14], r[5:1], r[8]});
			expect_val(1, 8'hFF);
			expect_val(8, {3'h0, r[0], 4'h4});
			expect_val(12, {r[15:14], r[5:1], r[8]});
			settle();
			idle();
			r = $random(seed);
			q = $random(seed);
			dma_end_process_en = r[19:18];
			dma_end_process = r[17:16];
			port_a_cfg = '{dout: r[7:0], dir: r[15:8]};
			port_b_cfg = '{dout: q[7:0], dir: q[15:8]};
			m = {4'h0, r[18], 3'h0};
			expect_val(0, exp_o({4'h0, r[16], 3'h0}, m, r[7:0], r[15:8], 8'h00));
			expect_val(1, exp_oe(m, r[15:8], 8'h00));
			m = {3'h0, r[19], 4'h0};
			expect_val(2, exp_o({3'h0, r[17], 4'h0}, m, q[7:0], q[15:8], 8'h00));
			expect_val(3, exp_oe(m, q[15:8], 8'h00));
			settle();
			idle();
			bus_clk_out_en = 1'b1;
			expect_val(9, 8'h01);
			expect_val(1, 8'h40);
			settle();
			idle();
			r = $random(seed);
			q = $random(seed);
			{dram_bank1_en, dram_bank0_en} = r[7:0];
			{dram_bank1, dram_bank0} = r[15:8];
			port_b_cfg = '{dout: q[7:0], dir: q[15:8]};
			expect_val(2, exp_o(r[15:8], r[7:0], q[7:0], q[15:8], 8'h00));
			expect_val(3, exp_oe(r[7:0], q[15:8], 8'h00));
			settle();
			idle();
			r = $random(seed);
			q = $random(seed);
			dma_acknowledge_en = r[2:0];
			dma_acknowledge = r[5:3];
			port_e_cfg = '{dout: q[7:0], dir: q[15:8]};
			port_b_cfg = '{dout: q[23:16], dir: q[31:24]};
			m = {r[1:0], 6'h00};
			expect_val(4, exp_o({r[4:3], 6'h00}, m, q[7:0], q[15:8], 8'h00));
			expect_val(5, exp_oe(m, q[15:8], 8'h00));
			m = {1'b0, r[2], 6'h00};
			expect_val(2, exp_o({1'b0, r[5], 6'h00}, m, q[23:16], q[31:24], 8'h00));
			expect_val(3, exp_oe(m, q[31:24], 8'h00));
			settle();
			idle();
			r = $random(seed);
			q = $random(seed);
			dma_ext_trigger_sel = 3'h7;
			port_e_cfg = '{dout: q[7:0], dir: 8'hFF};
			port_b_cfg = '{dout: q[15:8], dir: 8'hFF};
			board_e = r[7:0];
			board_b = r[15:8];
			expect_val(5, 8'hCF);
			expect_val(3, 8'hDF);
			expect_val(7, {1'b0, r[13], r[5:4], 4'h0});
			expect_val(10, (q[7:0] & 8'hCF) | (r[7:0] & 8'h30));
			expect_val(13, (q[15:8] & 8'hDF) | (r[15:8] & 8'h20));
			settle();
			idle();
			r = $random(seed);
			q = $random(seed);
			ext_irq_en = r[3:0];
			serial_clock_out_en = r[5:4];
			serial_clock_out = r[7:6];
			port_e_cfg = '{dout: q[7:0], dir: q[15:8]};
			board_e = q[23:16];
			m = {4'h0, r[5:4], 2'h0};
			io = {4'h0, r[3:0]};
			oe = exp_oe(m, q[15:8], io);
			lv = exp_o({4'h0, r[7:6], 2'h0}, m, q[7:0], q[15:8], io);
			expect_val(5, oe);
			expect_val(4, lv);
			expect_val(7, {4'h0, r[3:0] & (lv[3:0] | (q[19:16] & ~oe[3:0]))});
			expect_val(10, lv | (q[23:16] & ~oe));
			settle();
			idle();
			r = $random(seed);
			q = $random(seed);
			{serial0_rx_en, pwm_trigger_en_0, nmi_n, hw_standby_n} = r[3:0];
			port_f_cfg = '{dout: q[7:0], dir: 8'hFF};
			board_f = q[15:8];
			io = {7'h00, r[3] | r[2]};
			lv = (q[7:0] & ~io) | (q[15:8] & io);
			expect_val(6, ~io);
			expect_val(11, lv);
			expect_val(8, {4'h1, r[2] & lv[0], ~r[3] | lv[0], ~r[0], ~r[1]});
			settle();
		end
		finish_test();
	end
endmodule // tb_top
